// >>> rtl/rx_fifo_defs.svh
`ifndef RX_FIFO_DEFS_SVH
`define RX_FIFO_DEFS_SVH
`define FIFO_DEPTH 16
`define PTR_W 4
`define ADDR_W 12
// flags word index (0x0E5 = 0x394 / 4), then register byte addresses
`define OFF_FLAGS 12'h0E5
`define IDX_FLAGS 12'h0E5
`define ADDR_FLAGS 12'h394
`define ADDR_CTRL 12'h010
`define ADDR_STAT 12'h014
`define ADDR_CNT 12'h018
`define ADDR_DATA 12'h01C
// flag field positions
`define FLG_FIF_HI 7
`define FLG_FIF_LO 6
`define FLG_EMP 3
`define FLG_FULL 2
`define FLG_URF 1
`define FLG_OVF 0
// control bits
`define CTL_CLR 7
`define CTL_FRC 4
`define CTL_ISO 3
`define CTL_SPM 5
// status bits
`define ST_OVERWRITE_START_FLAG 0
`define ST_OVERWRITE_END_FLAG 1
`define ST_SETUP 2
`define ST_TX_STALL_BIT 3
`define ST_RX_STALL_BIT 4
`define CTL_RESET 8'h00
`define FIF_EMPTY 2'h0
`endif

// >>> rtl/rx_fifo_mem.sv
`timescale 1ns/1ps
`include "rx_fifo_defs.svh"
module rx_fifo_mem (
  input wire logic sys_clk,
  input wire logic we,
  input wire logic [`PTR_W-1:0] waddr,
  input wire logic [7:0] wdata,
  input wire logic [`PTR_W-1:0] raddr,
  output logic [7:0] rdata
);
  logic [7:0] mem [0:`FIFO_DEPTH-1];
  always_ff @(posedge sys_clk) begin
    if (we) begin
      mem[waddr] <= wdata;
    end
  end
  always_ff @(posedge sys_clk) begin
    rdata <= mem[raddr];
  end
endmodule

// >>> rtl/rx_fifo_pkg.sv
package rx_fifo_pkg;
  typedef struct packed {
    logic [1:0] fif;
    logic empty;
    logic full;
    logic underrun;
    logic overrun;
  } rx_flags_s;
  typedef struct packed {
    logic sof;
    logic setup_tok;
    logic setup_ack;
    logic in_tok;
    logic wr_byte;
    logic [7:0] wr_data;
    logic wr_count;
    logic [4:0] count;
  } usb_evt_s;
  typedef enum logic [2:0] {
    SU_IDLE = 3'b001,
    SU_OVW = 3'b010,
    SU_END = 3'b100
  } setup_state_e;
endpackage

// >>> rtl/usb_receive_fifo_status.sv
// Design decision made here: register access over APB.
`timescale 1ns/1ps
`include "rx_fifo_defs.svh"
// Overview of operation
// - byte count write updates index flags recording the new packet
// - write marker advance: 00 to 01, 10 to 11; reverse keeps flags
// - read-complete retires one set: 01/10 to 00, 11 to 10 or 01
// - single-packet mode shows index 00 or 01 only
// - iso: read-complete decrements now, reception increments at next SOF
// - empty flag tracks pointers equal with no rollover
// - full flag tracks rolled-over write pointer equal to read pointer
// - underrun sets on empty read, sticky, read pointer stays locked
// - iso: underrun still updates immediately
// - overrun on full write or count write at index 11; SETUP clears
// - overrun keeps write pointer locked at full
// - iso: overrun shows only at next SOF
// - engine sends LSb first; firmware orders bytes
// - control endpoint acknowledges every SETUP token
// - SETUP sets overwrite-start and flushes the FIFO like the clear bit
// - after SETUP ack: clear overwrite-start, set overwrite-end
// - overwrite-start resets and locks the read pointer
// - clearing overwrite-end clears underrun and resets read pointer
// - firmware clears overwrite-end before reading SETUP data
// - read-complete ignored while overwrite-start or overwrite-end set
// - setup-received flag forces NAK on IN tokens, even when stalled
// - iso data of frame n is read in frame n+1, dual-packet only
// - read-complete bit self-clears after the index flag update
module usb_receive_fifo_status (
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [`ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire rx_fifo_pkg::usb_evt_s usb_evt,
  output logic setup_ack_reg,
  output logic in_nak_reg,
  output logic [7:0] usb_tx_shift_reg
);
  import rx_fifo_pkg::*;
  logic [`PTR_W:0] wp_reg, rp_reg, wm_reg;
  logic [1:0] fif_reg;
  logic iso_pend_reg, ovf_pend_reg;
  logic urf_reg, ovf_reg;
  logic [7:0] ctrl_reg;
  logic [4:0] cnt0_reg, cnt1_reg;
  logic cnt_idx_reg;
  logic setup_flag_reg, tx_stall_reg, rx_stall_reg;
  setup_state_e su_reg;
  logic [7:0] rdata;
  rx_flags_s flags;
  logic apb_wr, apb_rd, empty, full;
  logic sel_flags, sel_ctrl, sel_stat, sel_cnt, sel_data;
  logic rd_data, rd_cnt, frc_req, flush, wr_ok, ovw_clr;
  logic overwrite_start_flag, overwrite_end_flag, iso, spm;

  function automatic logic [1:0] fif_inc(input logic [1:0] f,
                                         input logic single);
    if (single) begin
      fif_inc = 2'b01;
    end else if (f == 2'b00) begin
      fif_inc = 2'b01;
    end else begin
      fif_inc = 2'b11;
    end
  endfunction
  function automatic logic [1:0] fif_dec(input logic [1:0] f,
                                         input logic odd);
    if (f == 2'b11) begin
      fif_dec = odd ? 2'b01 : 2'b10;
    end else begin
      fif_dec = 2'b00;
    end
  endfunction

  assign apb_wr = psel && penable && pwrite;
  assign apb_rd = psel && penable && !pwrite;
  assign overwrite_start_flag = (su_reg == SU_OVW);
  assign overwrite_end_flag = (su_reg == SU_END);
  assign iso = ctrl_reg[`CTL_ISO];
  assign spm = ctrl_reg[`CTL_SPM] && !iso;

  always_comb begin
    sel_flags = 1'b0;
    sel_ctrl = 1'b0;
    sel_stat = 1'b0;
    sel_cnt = 1'b0;
    sel_data = 1'b0;
    if (paddr == `ADDR_FLAGS) begin
      sel_flags = 1'b1;
    end else if (paddr == `ADDR_CTRL) begin
      sel_ctrl = 1'b1;
    end else if (paddr == `ADDR_STAT) begin
      sel_stat = 1'b1;
    end else if (paddr == `ADDR_CNT) begin
      sel_cnt = 1'b1;
    end else if (paddr == `ADDR_DATA) begin
      sel_data = 1'b1;
    end
  end

  assign empty = (wp_reg == rp_reg) && (wp_reg == wm_reg);
  assign full = (wp_reg[`PTR_W] != rp_reg[`PTR_W]) &&
                (wp_reg[`PTR_W-1:0] == rp_reg[`PTR_W-1:0]);
  assign rd_data = apb_rd && sel_data;
  assign rd_cnt = apb_rd && sel_cnt;
  assign flush = (apb_wr && sel_ctrl && pwdata[`CTL_CLR]) ||
                 usb_evt.setup_tok;
  assign frc_req = apb_wr && sel_ctrl && pwdata[`CTL_FRC] &&
                   !overwrite_start_flag && !overwrite_end_flag;
  assign wr_ok = usb_evt.wr_byte && !full;
  assign ovw_clr = overwrite_end_flag && apb_wr && sel_stat && !pwdata[`ST_OVERWRITE_END_FLAG];

  rx_fifo_mem u_mem (
    .sys_clk(sys_clk),
    .we(wr_ok),
    .waddr(wp_reg[`PTR_W-1:0]),
    .wdata(usb_evt.wr_data),
    .raddr(rp_reg[`PTR_W-1:0]),
    .rdata(rdata)
  );

  // write pointer and marker
  always_ff @(posedge sys_clk) begin
    if (!rst_n || flush) begin
      wp_reg <= '0;
      wm_reg <= '0;
    end else begin
      if (wr_ok) begin
        wp_reg <= wp_reg + 1'b1;
      end
      if (usb_evt.wr_count) begin
        wm_reg <= wp_reg;
      end
    end
  end

  // read pointer
  always_ff @(posedge sys_clk) begin
    if (!rst_n || flush || overwrite_start_flag || ovw_clr) begin
      rp_reg <= '0;
    end else if (rd_data && !(wp_reg == rp_reg)) begin
      rp_reg <= rp_reg + 1'b1;
    end
  end

  // byte counts, toggled index
  always_ff @(posedge sys_clk) begin
    if (!rst_n || flush) begin
      cnt0_reg <= '0;
      cnt1_reg <= '0;
      cnt_idx_reg <= 1'b0;
    end else if (usb_evt.wr_count && fif_reg != 2'b11) begin
      if (cnt_idx_reg) begin
        cnt1_reg <= usb_evt.count;
      end else begin
        cnt0_reg <= usb_evt.count;
      end
      cnt_idx_reg <= spm ? 1'b0 : !cnt_idx_reg;
    end
  end

  // index flags; count write acts as write marker advance
  always_ff @(posedge sys_clk) begin
    if (!rst_n || flush) begin
      fif_reg <= `FIF_EMPTY;
      iso_pend_reg <= 1'b0;
    end else begin
      if (frc_req) begin
        fif_reg <= fif_dec(fif_reg, cnt_idx_reg);
      end else if (iso && usb_evt.sof && iso_pend_reg) begin
        fif_reg <= fif_inc(fif_reg, 1'b0);
      end else if (usb_evt.wr_count && !iso && fif_reg != 2'b11) begin
        fif_reg <= fif_inc(fif_reg, spm);
      end
      if (iso && usb_evt.sof) begin
        iso_pend_reg <= 1'b0;
      end else if (iso && usb_evt.wr_count) begin
        iso_pend_reg <= 1'b1;
      end
    end
  end

  // underrun, set wins over clear
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      urf_reg <= 1'b0;
    end else if ((rd_data && empty) || (rd_cnt && fif_reg == 2'b00)) begin
      urf_reg <= 1'b1;
    end else if (ovw_clr) begin
      urf_reg <= 1'b0;
    end else if (apb_wr && sel_flags && !pwdata[`FLG_URF]) begin
      urf_reg <= 1'b0;
    end
  end

  // overrun, deferred to SOF in iso
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      ovf_reg <= 1'b0;
      ovf_pend_reg <= 1'b0;
    end else begin
      if ((usb_evt.wr_byte && full) ||
          (usb_evt.wr_count && fif_reg == 2'b11)) begin
        if (iso) begin
          ovf_pend_reg <= 1'b1;
        end else begin
          ovf_reg <= 1'b1;
        end
      end else if (iso && usb_evt.sof && ovf_pend_reg) begin
        ovf_reg <= 1'b1;
        ovf_pend_reg <= 1'b0;
      end else if (usb_evt.setup_tok && ovf_reg) begin
        ovf_reg <= 1'b0;
      end else if (apb_wr && sel_flags && !pwdata[`FLG_OVF]) begin
        ovf_reg <= 1'b0;
      end
    end
  end

  // control register; read-complete self-clears
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      ctrl_reg <= `CTL_RESET;
    end else if (apb_wr && sel_ctrl) begin
      ctrl_reg <= {1'b0, 1'b0, pwdata[5], 1'b0, pwdata[3], 3'b000};
    end
  end

  // setup overwrite sequence
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      su_reg <= SU_IDLE;
    end else begin
      case (su_reg)
        SU_IDLE: begin
          if (usb_evt.setup_tok) begin
            su_reg <= SU_OVW;
          end
        end
        SU_OVW: begin
          if (usb_evt.setup_ack) begin
            su_reg <= SU_END;
          end
        end
        SU_END: begin
          if (usb_evt.setup_tok) begin
            su_reg <= SU_OVW;
          end else if (ovw_clr) begin
            su_reg <= SU_IDLE;
          end
        end
        default: su_reg <= SU_IDLE;
      endcase
    end
  end

  // setup-received and stall bits
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      setup_flag_reg <= 1'b0;
      tx_stall_reg <= 1'b0;
      rx_stall_reg <= 1'b0;
    end else begin
      if (usb_evt.setup_tok) begin
        setup_flag_reg <= 1'b1;
      end else if (apb_wr && sel_stat && !pwdata[`ST_SETUP]) begin
        setup_flag_reg <= 1'b0;
      end
      if (apb_wr && sel_stat) begin
        tx_stall_reg <= pwdata[`ST_TX_STALL_BIT];
        rx_stall_reg <= pwdata[`ST_RX_STALL_BIT];
      end
    end
  end

  // handshake outputs
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      setup_ack_reg <= 1'b0;
      in_nak_reg <= 1'b0;
    end else begin
      setup_ack_reg <= usb_evt.setup_tok;
      in_nak_reg <= usb_evt.in_tok &&
                    (setup_flag_reg || tx_stall_reg);
    end
  end

  // byte to engine, bit-reversed so shift-out from msb gives LSb first
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      usb_tx_shift_reg <= 8'h00;
    end else if (wr_ok) begin
      usb_tx_shift_reg <= {<<{usb_evt.wr_data}};
    end
  end

  always_comb begin
    flags.fif = fif_reg;
    flags.empty = empty;
    flags.full = full;
    flags.underrun = urf_reg;
    flags.overrun = ovf_reg;
  end

  // apb slave, zero wait states
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      prdata <= 32'h0000_0000;
      pready <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      pready <= psel && !penable;
      pslverr <= psel && !penable && !(sel_flags || sel_ctrl ||
                 sel_stat || sel_cnt || sel_data);
      prdata <= 32'h0000_0000;
      if (psel && !penable && !pwrite) begin
        if (sel_flags) begin
          prdata <= {24'h000000, flags.fif, 2'b00, flags.empty,
                     flags.full, flags.underrun, flags.overrun};
        end else if (sel_ctrl) begin
          prdata <= {24'h000000, ctrl_reg};
        end else if (sel_stat) begin
          prdata <= {27'h0000000, rx_stall_reg, tx_stall_reg,
                     setup_flag_reg, overwrite_end_flag, overwrite_start_flag};
        end else if (sel_cnt) begin
          prdata <= {27'h0000000, cnt_idx_reg ? cnt1_reg : cnt0_reg};
        end else if (sel_data) begin
          prdata <= {24'h000000, rdata};
        end
      end
    end
  end

  AST_EMPTY: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (wp_reg == rp_reg && wp_reg == wm_reg) |-> flags.empty)
    else $error("empty flag wrong");
  AST_FULL: assert property (@(posedge sys_clk) disable iff (!rst_n)
    full |-> !flags.empty)
    else $error("full and empty together");
  AST_URF_STICKY: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (urf_reg && !ovw_clr && !(apb_wr && sel_flags)) |=> urf_reg)
    else $error("underrun lost");
  AST_URF_SET: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (rd_data && empty) |=> urf_reg)
    else $error("underrun not set");
  AST_WP_LOCK: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (usb_evt.wr_byte && full && !flush) |=> $stable(wp_reg))
    else $error("write pointer moved when full");
  AST_SPM: assert property (@(posedge sys_clk) disable iff (!rst_n)
    spm |=> fif_reg != 2'b11 || !$past(spm))
    else $error("single mode index 11");
  AST_OVW_SEQ: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (overwrite_start_flag && usb_evt.setup_ack && !usb_evt.setup_tok) |=> overwrite_end_flag)
    else $error("overwrite end not set");
  AST_SETUP: assert property (@(posedge sys_clk) disable iff (!rst_n)
    usb_evt.setup_tok |=> overwrite_start_flag && wp_reg == '0 && setup_ack_reg)
    else $error("setup flush failed");
  AST_RP_LOCK: assert property (@(posedge sys_clk) disable iff (!rst_n)
    overwrite_start_flag |=> rp_reg == '0)
    else $error("read pointer not locked");
  AST_NAK: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (usb_evt.in_tok && setup_flag_reg) |=> in_nak_reg)
    else $error("in token not naked");
  COV_SETUP: cover property (@(posedge sys_clk) overwrite_start_flag ##[1:50] overwrite_end_flag);
  COV_FULL: cover property (@(posedge sys_clk) full);
  COV_TWO: cover property (@(posedge sys_clk) fif_reg == 2'b11);
endmodule

// >>> sim/usb_host_model.sv
`timescale 1ns/1ps
module usb_host_model (
  input wire logic sys_clk,
  output rx_fifo_pkg::usb_evt_s usb_evt
);
  import rx_fifo_pkg::*;
  usb_evt_s e;
  initial usb_evt = '0;
  // one event pulse after a stall, then scrambled idle data lines
  task automatic fire(input int unsigned gap);
    repeat (gap) @(posedge sys_clk);
    @(posedge sys_clk);
    usb_evt <= e;
    @(posedge sys_clk);
    usb_evt <= {5'h00, ~e.wr_data, 1'b0, ~e.count};
  endtask
  // bit 0 of each byte leaves the serial stream first
  task automatic put_byte(input logic [7:0] d, input int unsigned gap);
    e = '0;
    e.wr_byte = 1'b1;
    e.wr_data = d;
    fire(gap);
  endtask
  // count goes out only after all its bytes
  task automatic put_count(input logic [4:0] n);
    e = '0;
    e.wr_count = 1'b1;
    e.count = n;
    fire(0);
  endtask
  // bits: sof, setup token, setup handshake, in token
  task automatic put_token(input logic [3:0] bits);
    e = '0;
    {e.sof, e.setup_tok, e.setup_ack, e.in_tok} = bits;
    fire(0);
  endtask
endmodule

// >>> sim/usb_receive_fifo_status_tb.sv
`timescale 1ns/1ps
`include "rx_fifo_defs.svh"
module usb_receive_fifo_status_tb;
  import rx_fifo_pkg::*;
  logic sys_clk = 1'b0;
  logic rst_n;
  logic psel;
  logic penable;
  logic pwrite;
  logic [`ADDR_W-1:0] paddr;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  usb_evt_s usb_evt;
  logic setup_ack_reg;
  logic in_nak_reg;
  logic [7:0] usb_tx_shift_reg;
  int failures = 0;
  int checked = 0;
  logic [31:0] seed = 32'h0000BCE1;
  logic [7:0] exp_q[$];
  logic [31:0] rd;
  logic last_err;
  logic [7:0] last_b;

  always #20 sys_clk = ~sys_clk;

  usb_receive_fifo_status usb_receive_fifo_status_i (
    .sys_clk(sys_clk), .rst_n(rst_n), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .usb_evt(usb_evt),
    .setup_ack_reg(setup_ack_reg), .in_nak_reg(in_nak_reg),
    .usb_tx_shift_reg(usb_tx_shift_reg));
  usb_host_model usb_host_model_i (.sys_clk(sys_clk), .usb_evt(usb_evt));

  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  function automatic logic [7:0] bit_rev(input logic [7:0] b);
    logic [7:0] r;
    for (int i = 0; i < 8; i++) r[i] = b[7 - i];
    return r;
  endfunction

  task automatic finish_test();
    if (failures == 0 && checked > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  task automatic chk(input string what, input logic [31:0] exp,
                     input logic [31:0] got);
    checked++;
    if (got !== exp) begin
      $display("ERROR %s expected %h seen %h", what, exp, got);
      failures++;
    end
  endtask
  // one apb transfer, held until pready is sampled high
  task automatic apb(input logic w, input logic [11:0] a,
                     input logic [31:0] wd);
    @(posedge sys_clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= wd;
    @(posedge sys_clk);
    penable <= 1'b1;
    do @(posedge sys_clk); while (pready !== 1'b1);
    rd = prdata;
    last_err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wr(input logic [11:0] a, input logic [7:0] v);
    apb(1'b1, a, {24'h000000, v});
  endtask
  task automatic rdr(input logic [11:0] a);
    apb(1'b0, a, 32'h00000000);
  endtask
  task automatic flags_is(input string what, input logic [7:0] exp);
    rdr(`ADDR_FLAGS);
    chk(what, {24'h000000, exp}, {24'h000000, rd[7:0] & 8'hCF});
  endtask
  task automatic pkt(input int n, input logic cnt);
    for (int i = 0; i < n; i++) begin
      seed = lfsr(seed);
      last_b = seed[7:0];
      exp_q.push_back(last_b);
      usb_host_model_i.put_byte(last_b, seed[9:8]);
    end
    if (cnt) usb_host_model_i.put_count(5'(n));
  endtask
  task automatic pull(input int n);
    for (int i = 0; i < n; i++) begin
      rdr(`ADDR_DATA);
      chk("fifo_byte", {24'h000000, exp_q.pop_front()}, rd & 32'hFF);
    end
  endtask
  task automatic in_tok(input logic exp);
    usb_host_model_i.put_token(4'h1);
    #1;
    chk("in_nak", {31'h00000000, exp}, {31'h00000000, in_nak_reg});
  endtask

  initial begin
    repeat (20000) @(posedge sys_clk);
    failures++;
    finish_test();
  end

  initial begin
    rst_n <= 1'b0;
    psel <= 1'b0;
    penable <= 1'b0;
    pwrite <= 1'b0;
    paddr <= '0;
    pwdata <= '0;
    repeat (5) @(posedge sys_clk);
    rst_n <= 1'b1;
    flags_is("flags_reset", 8'h08);
    rdr(`ADDR_CTRL);
    chk("ctrl_reset", 32'h00000000, rd);
    rdr(12'h0FC);
    chk("unmapped", 32'h00000001, {rd[30:0], last_err});
    pkt(3, 1'b1);
    flags_is("one_set", 8'h40);
    chk("shift", 32'(bit_rev(last_b)), 32'(usb_tx_shift_reg));
    pkt(3, 1'b1);
    flags_is("two_sets", 8'hC0);
    usb_host_model_i.put_count(5'h00);
    flags_is("count_at_11", 8'hC1);
    seed = lfsr(seed);
    wr(`ADDR_FLAGS, seed[7:0] & 8'hFC);
    flags_is("ovf_clear", 8'hC0);
    pull(3);
    wr(`ADDR_CTRL, 8'h10);
    flags_is("one_left", 8'h80);
    rdr(`ADDR_CTRL);
    chk("frc_self_clear", 32'h00000000, rd & 32'h00000010);
    pull(3);
    wr(`ADDR_CTRL, 8'h10);
    flags_is("all_released", 8'h08);
    wr(`ADDR_CTRL, 8'h10);
    flags_is("release_at_00", 8'h08);
    rdr(`ADDR_DATA);
    flags_is("underrun", 8'h0A);
    wr(`ADDR_FLAGS, 8'h00);
    flags_is("urf_clear", 8'h08);
    pkt(17, 1'b0);
    flags_is("full_ovf", 8'h05);
    pull(1);
    exp_q.delete();
    usb_host_model_i.put_token(4'h4);
    #1;
    chk("setup_ack", 32'h00000001, {31'h00000000, setup_ack_reg});
    rdr(`ADDR_STAT);
    chk("ovw_start", 32'h00000005, rd & 32'h0000001F);
    flags_is("setup_flush", 8'h08);
    rdr(`ADDR_DATA);
    flags_is("locked_read", 8'h0A);
    pkt(3, 1'b1);
    usb_host_model_i.put_token(4'h2);
    rdr(`ADDR_STAT);
    chk("ovw_end", 32'h00000006, rd & 32'h0000001F);
    wr(`ADDR_CTRL, 8'h10);
    flags_is("frc_blocked", 8'h42);
    wr(`ADDR_STAT, 8'h1E);
    in_tok(1'b1);
    wr(`ADDR_STAT, 8'h04);
    flags_is("ovw_end_clear", 8'h40);
    pull(3);
    wr(`ADDR_STAT, 8'h00);
    in_tok(1'b0);
    wr(`ADDR_CTRL, 8'h10);
    flags_is("setup_released", 8'h08);
    wr(`ADDR_CTRL, 8'h20);
    pkt(2, 1'b1);
    pkt(2, 1'b1);
    rdr(`ADDR_FLAGS);
    chk("single_index", 32'h00000000, rd & 32'h00000080);
    wr(`ADDR_CTRL, 8'hA0);
    flags_is("flush", 8'h08);
    exp_q.delete();
    wr(`ADDR_CTRL, 8'h08);
    pkt(3, 1'b1);
    flags_is("iso_pending", 8'h00);
    usb_host_model_i.put_token(4'h8);
    flags_is("iso_sof", 8'h40);
    pull(3);
    wr(`ADDR_CTRL, 8'h18);
    flags_is("iso_release", 8'h08);
    rdr(`ADDR_DATA);
    flags_is("iso_underrun", 8'h0A);
    wr(`ADDR_FLAGS, 8'h00);
    pkt(17, 1'b0);
    flags_is("iso_ovf_held", 8'h04);
    usb_host_model_i.put_token(4'h8);
    flags_is("iso_ovf_sof", 8'h05);
    finish_test();
  end
endmodule
